// File: hw/pscg_pkg.sv
// Constants for the power-save and clock-gating block: register map,
// field positions, reset values, state codes and wake timing.
// Assumes a single 10 MHz core clock and an APB register bus.
package pscg_pkg;

  // APB register byte addresses
  localparam logic [7:0] PSCG_CLOCK_DIVIDER_REGISTER_OFS = 8'h00;
  localparam logic [7:0] PSCG_GATE1_OFS  = 8'h04;
  localparam logic [7:0] PSCG_GATE2_OFS  = 8'h08;
  localparam logic [7:0] PSCG_STAT_OFS   = 8'h0C;

  // Clock divider register fields
  localparam int PSCG_ROI_BIT   = 15;
  localparam int PSCG_RATIO_HI  = 14;
  localparam int PSCG_RATIO_LO  = 12;
  localparam int PSCG_CPU_DIVIDE_ENABLE_BIT = 11;
  localparam logic [15:0] PSCG_CLOCK_DIVIDER_REGISTER_MASK = 16'hF800;
  localparam logic [15:0] PSCG_CLOCK_DIVIDER_REGISTER_RST  = 16'h0000;

  // Implemented disable bits of the two gate registers
  localparam logic [15:0] PSCG_GATE1_MASK = 16'h38A9;
  localparam logic [15:0] PSCG_GATE2_MASK = 16'hC303;
  localparam logic [15:0] PSCG_GATE_RST   = 16'h0000;
  localparam int PSCG_ADC_BIT = 0;

  // Power-save instruction operand codes
  localparam logic PSCG_OP_SLEEP = 1'b0;
  localparam logic PSCG_OP_IDLE  = 1'b1;

  // Idle wake latency: 2 to 4 cycles at 100 ns per cycle
  localparam int PSCG_CLK_PERIOD_NS = 100;
  localparam int PSCG_WAKE_MIN_NS   = 200;
  localparam int PSCG_WAKE_CYC =
    (PSCG_WAKE_MIN_NS + PSCG_CLK_PERIOD_NS - 1) / PSCG_CLK_PERIOD_NS;

  // Power states
  typedef enum logic [1:0] {
    PSCG_RUN   = 2'b00,
    PSCG_SLEEP = 2'b01,
    PSCG_IDLE  = 2'b10,
    PSCG_WAKE  = 2'b11
  } pscg_state_e;

endpackage

// File: hw/pscg_power_save_clock_gating.sv
// Power-save controller: sleep, idle, doze divider and peripheral gates.
// Assumes core, interrupt controller and watchdog run on core_clk, so
// their strobes need no synchroniser; registers sit on APB.
`timescale 1ns/1ns
`default_nettype none

module pscg_power_save_clock_gating
  import pscg_pkg::*;
#(
  parameter int          ADDR_W       = 8,
  parameter int          WAKE_CYCLES  = PSCG_WAKE_CYC,
  parameter logic [15:0] PRESENT1     = PSCG_GATE1_MASK,
  parameter logic [15:0] PRESENT2     = PSCG_GATE2_MASK
) (
  input  wire  logic              core_clk,
  input  wire  logic              sys_rst,
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [ADDR_W-1:0] paddr,
  input  wire  logic [31:0]       pwdata,
  output var   logic [31:0]       prdata,
  output var   logic              pready,
  output var   logic              pslverr,
  input  wire  logic              power_save_exec,
  input  wire  logic              power_save_operand,
  input  wire  logic              irq_pending,
  input  wire  logic              wdt_timeout,
  input  wire  logic              wdt_enabled,
  input  wire  logic              clock_failure_monitor_enabled,
  input  wire  logic [2:0]        current_clock_select,
  output var   logic              cpu_clk_en,
  output var   logic              cpu_resume,
  output var   logic              sys_clk_run,
  output var   logic              osc_on,
  output var   logic              low_power_rc_run,
  output var   logic              clock_failure_monitor_active,
  output var   logic              wdt_clear,
  output var   logic              periph_sysclk_en,
  output var   logic [15:0]       module_gate_en1,
  output var   logic [15:0]       module_gate_en2,
  output var   logic              analog_cfg_en,
  output var   logic [2:0]        restart_clock_select
);

  // Elaboration checks
  initial begin
    if (ADDR_W < 4 || ADDR_W > 8)
      $error("ADDR_W must lie in 4..8");
    if (WAKE_CYCLES < 2 || WAKE_CYCLES > 4)
      $error("WAKE_CYCLES must lie in 2..4");
  end

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    pscg_state_e state;
    logic [2:0]  wake_cnt;
    logic [6:0]  div_cnt;
    logic [15:0] clock_divider_register;
    logic [15:0] gate1;
    logic [15:0] gate2;
    logic [2:0]  clk_sel;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        cpu_en;
    logic        resume;
    logic        sys_run;
    logic        osc;
    logic        low_power_rc_clock;
    logic        clock_failure_monitor;
    logic        wclr;
    logic        psys;
    logic [15:0] en1;
    logic [15:0] en2;
    logic        acfg;
  } pscg_regs_s;

  pscg_regs_s r_reg;
  pscg_regs_s r_next;

  // Mask of the doze divider for a ratio code; 1:1 gives zero
  function automatic logic [6:0] pscg_doze_mask(input logic [2:0] ratio);
    pscg_doze_mask = 7'(({7'h00, 1'b1} << ratio) - 8'h01);
  endfunction

  // Byte address compare over the implemented address width
  function automatic logic pscg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        ofs);
    pscg_hit = (a == ofs[ADDR_W-1:0]);
  endfunction

  logic       wake_evt;
  logic       doze_on;
  logic [2:0] ratio;
  logic       doze_tick;
  logic       wr_go;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    r_next    = r_reg;
    ratio     = r_reg.clock_divider_register[PSCG_RATIO_HI:PSCG_RATIO_LO];
    doze_on   = r_reg.clock_divider_register[PSCG_CPU_DIVIDE_ENABLE_BIT];
    // Interrupt stays a level, so one arriving during entry wakes next
    wake_evt  = irq_pending || wdt_timeout;
    // Tick keeps CPU edges aligned with the undivided peripheral clock
    doze_tick = !doze_on ||
                ((r_reg.div_cnt & pscg_doze_mask(ratio)) == 7'h00);
    wr_go     = psel && penable && r_reg.ready && pwrite;

    r_next.wclr   = 1'b0;
    r_next.resume = 1'b0;
    r_next.div_cnt = 7'(r_reg.div_cnt + 7'h01);

    // Power state machine
    unique case (r_reg.state)
      PSCG_RUN: begin
        if (power_save_exec) begin
          r_next.wclr = 1'b1;
          if (power_save_operand == PSCG_OP_SLEEP) begin
            r_next.state   = PSCG_SLEEP;
            r_next.clk_sel = current_clock_select;
          end else begin
            r_next.state = PSCG_IDLE;
          end
        end
      end
      PSCG_SLEEP, PSCG_IDLE: begin
        if (wake_evt) begin
          r_next.state    = PSCG_WAKE;
          r_next.wake_cnt = 3'd1;
        end
      end
      PSCG_WAKE: begin
        if (r_reg.wake_cnt >= 3'(WAKE_CYCLES)) begin
          r_next.state  = PSCG_RUN;
          r_next.resume = 1'b1;
        end else begin
          r_next.wake_cnt = 3'(r_reg.wake_cnt + 3'd1);
        end
      end
    endcase

    // Clock source outputs per state
    r_next.sys_run = (r_next.state != PSCG_SLEEP);
    r_next.osc     = (r_next.state != PSCG_SLEEP);
    r_next.psys    = (r_next.state != PSCG_SLEEP);
    r_next.clock_failure_monitor    = clock_failure_monitor_enabled && (r_next.state != PSCG_SLEEP);
    r_next.low_power_rc_clock    = (r_next.state == PSCG_SLEEP) ? wdt_enabled
                   : (wdt_enabled || clock_failure_monitor_enabled);
    // CPU clock enable: only in run, divided while dozing
    r_next.cpu_en  = (r_next.state == PSCG_RUN) && doze_tick;

    // Register writes
    if (wr_go && pscg_hit(paddr, PSCG_CLOCK_DIVIDER_REGISTER_OFS))
      r_next.clock_divider_register = pwdata[15:0] & PSCG_CLOCK_DIVIDER_REGISTER_MASK;
    if (wr_go && pscg_hit(paddr, PSCG_GATE1_OFS))
      r_next.gate1 = pwdata[15:0] & PSCG_GATE1_MASK;
    if (wr_go && pscg_hit(paddr, PSCG_GATE2_OFS))
      r_next.gate2 = pwdata[15:0] & PSCG_GATE2_MASK;
    // Hardware exit from doze overrides a same-cycle software write
    if (irq_pending && r_reg.clock_divider_register[PSCG_ROI_BIT])
      r_next.clock_divider_register[PSCG_CPU_DIVIDE_ENABLE_BIT] = 1'b0;

    // Gates follow the registers one cycle later; absent modules stay off
    r_next.en1  = ~r_reg.gate1 & PRESENT1 & PSCG_GATE1_MASK;
    r_next.en2  = ~r_reg.gate2 & PRESENT2 & PSCG_GATE2_MASK;
    r_next.acfg = r_next.en1[PSCG_ADC_BIT];

    // APB: setup cycle prepares a zero-wait access phase
    r_next.ready  = psel && !penable;
    r_next.slverr = 1'b0;
    r_next.rdata  = 32'h0000_0000;
    if (psel && !penable) begin
      if (pscg_hit(paddr, PSCG_CLOCK_DIVIDER_REGISTER_OFS))
        r_next.rdata = {16'h0000, r_reg.clock_divider_register};
      else if (pscg_hit(paddr, PSCG_GATE1_OFS))
        r_next.rdata = {16'h0000, r_reg.gate1};
      else if (pscg_hit(paddr, PSCG_GATE2_OFS))
        r_next.rdata = {16'h0000, r_reg.gate2};
      else if (pscg_hit(paddr, PSCG_STAT_OFS))
        r_next.rdata = {24'h00_0000, 1'b0, r_reg.clk_sel,
                        r_reg.cpu_en, r_reg.sys_run, r_reg.state};
      else
        r_next.slverr = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; every present module enabled out of reset

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg         <= '0;
      r_reg.state   <= PSCG_RUN;
      r_reg.clock_divider_register  <= PSCG_CLOCK_DIVIDER_REGISTER_RST;
      r_reg.gate1   <= PSCG_GATE_RST;
      r_reg.gate2   <= PSCG_GATE_RST;
      r_reg.sys_run <= 1'b1;
      r_reg.osc     <= 1'b1;
      r_reg.psys    <= 1'b1;
      r_reg.en1     <= PRESENT1 & PSCG_GATE1_MASK;
      r_reg.en2     <= PRESENT2 & PSCG_GATE2_MASK;
      r_reg.acfg    <= PRESENT1[PSCG_ADC_BIT];
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops

  assign prdata               = r_reg.rdata;
  assign pready               = r_reg.ready;
  assign pslverr              = r_reg.slverr;
  assign cpu_clk_en           = r_reg.cpu_en;
  assign cpu_resume           = r_reg.resume;
  assign sys_clk_run          = r_reg.sys_run;
  assign osc_on               = r_reg.osc;
  assign low_power_rc_run     = r_reg.low_power_rc_clock;
  assign clock_failure_monitor_active          = r_reg.clock_failure_monitor;
  assign wdt_clear            = r_reg.wclr;
  assign periph_sysclk_en     = r_reg.psys;
  assign module_gate_en1      = r_reg.en1;
  assign module_gate_en2      = r_reg.en2;
  assign analog_cfg_en        = r_reg.acfg;
  assign restart_clock_select = r_reg.clk_sel;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_sleep_entry;
    r_reg.state == PSCG_RUN && power_save_exec &&
    power_save_operand == PSCG_OP_SLEEP
      |=> !sys_clk_run && !osc_on && wdt_clear && !cpu_clk_en;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry did not stop clocks");

  property p_idle_entry;
    r_reg.state == PSCG_RUN && power_save_exec &&
    power_save_operand == PSCG_OP_IDLE
      |=> sys_clk_run && periph_sysclk_en && !cpu_clk_en && wdt_clear;
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle entry wrong");

  property p_wake;
    (r_reg.state == PSCG_SLEEP || r_reg.state == PSCG_IDLE) && irq_pending
      |=> r_reg.state == PSCG_WAKE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("enabled interrupt did not wake");

  property p_clock_failure_monitor_sleep;
    r_reg.state == PSCG_SLEEP |-> !clock_failure_monitor_active && !periph_sysclk_en;
  endproperty
  a_clock_failure_monitor_sleep: assert property (p_clock_failure_monitor_sleep)
    else $error("monitor or peripherals active in sleep");

  property p_low_power_rc_clock_sleep;
    r_reg.state == PSCG_SLEEP && $stable(wdt_enabled)
      |-> low_power_rc_run == wdt_enabled;
  endproperty
  a_low_power_rc_clock_sleep: assert property (p_low_power_rc_clock_sleep)
    else $error("slow RC wrong in sleep");

  property p_resume;
    r_reg.state == PSCG_WAKE && r_reg.wake_cnt == 3'd1
      |-> ##(WAKE_CYCLES) cpu_resume ##1 cpu_clk_en || doze_on;
  endproperty
  a_resume: assert property (p_resume)
    else $error("CPU resume latency wrong");

  property p_clk_restore;
    r_reg.state == PSCG_RUN && power_save_exec &&
    power_save_operand == PSCG_OP_SLEEP
      |=> restart_clock_select == $past(current_clock_select);
  endproperty
  a_clk_restore: assert property (p_clk_restore)
    else $error("entry clock source not kept");

  property p_gate_delay;
    wr_go && pscg_hit(paddr, PSCG_GATE1_OFS)
      |=> ##1 module_gate_en1 ==
              (~($past(pwdata[15:0], 2)) & PRESENT1 & PSCG_GATE1_MASK);
  endproperty
  a_gate_delay: assert property (p_gate_delay)
    else $error("gate did not follow write");

  property p_gate_unimpl;
    (r_reg.gate1 & ~PSCG_GATE1_MASK) == 16'h0000 &&
    (r_reg.gate2 & ~PSCG_GATE2_MASK) == 16'h0000;
  endproperty
  a_gate_unimpl: assert property (p_gate_unimpl)
    else $error("unimplemented gate bit set");

  property p_analog;
    analog_cfg_en == module_gate_en1[PSCG_ADC_BIT];
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog enable disagrees with ADC gate");

  property p_roi;
    irq_pending && r_reg.clock_divider_register[PSCG_ROI_BIT] |=> !doze_on;
  endproperty
  a_roi: assert property (p_roi)
    else $error("interrupt did not end doze");

  // Time-out wakes as well as an interrupt; the pulse is only one cycle
  property p_wdt_wake;
    (r_reg.state == PSCG_SLEEP || r_reg.state == PSCG_IDLE) && wdt_timeout
      |=> r_reg.state == PSCG_WAKE;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog time-out did not wake");

  // Slow RC follows either user in idle once the levels have settled
  property p_low_power_rc_clock_idle;
    r_reg.state == PSCG_IDLE && $stable(wdt_enabled) &&
    $stable(clock_failure_monitor_enabled)
      |-> low_power_rc_run == (wdt_enabled || clock_failure_monitor_enabled);
  endproperty
  a_low_power_rc_clock_idle: assert property (p_low_power_rc_clock_idle)
    else $error("slow RC wrong in idle");

  property p_gate_delay2;
    wr_go && pscg_hit(paddr, PSCG_GATE2_OFS)
      |=> ##1 module_gate_en2 ==
              (~($past(pwdata[15:0], 2)) & PRESENT2 & PSCG_GATE2_MASK);
  endproperty
  a_gate_delay2: assert property (p_gate_delay2)
    else $error("second gate did not follow write");

  // No CPU edge while halted or waking
  property p_cpu_halt;
    r_reg.state != PSCG_RUN |-> !cpu_clk_en;
  endproperty
  a_cpu_halt: assert property (p_cpu_halt)
    else $error("CPU clock enabled outside run");

  c_sleep_wake: cover property (r_reg.state == PSCG_SLEEP ##1
                                r_reg.state == PSCG_WAKE);
  c_idle_wake:  cover property (r_reg.state == PSCG_IDLE ##1
                                r_reg.state == PSCG_WAKE);
  c_doze:       cover property (doze_on && ratio == 3'd7 && cpu_clk_en);
  c_wdt_wake:   cover property (r_reg.state == PSCG_SLEEP && wdt_timeout);
  c_gate_write: cover property (wr_go && pscg_hit(paddr, PSCG_GATE2_OFS));

endmodule

`default_nettype wire

// File: verification/pscg_core_model.sv
// Stand-in for the processor core and the interrupt and watchdog sources.
// Assumes the bench raises request levels just after a core_clk edge.
`timescale 1ns/1ns
`default_nettype none

module pscg_core_model (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic req_save,
  input  wire logic req_op,
  input  wire logic req_irq,
  input  wire logic req_wdt,
  output var  logic power_save_exec,
  output var  logic power_save_operand,
  output var  logic irq_pending,
  output var  logic wdt_timeout
);

  logic save_d;
  logic wdt_d;

  ////////////////////////////////////////////////////////////////////////
  // One strobe per save or watchdog request edge, the interrupt passed as a level; the operand toggles outside the strobe
  // so the block cannot lean on a stale value
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      save_d             <= 1'b0;
      wdt_d              <= 1'b0;
      power_save_exec    <= 1'b0;
      power_save_operand <= 1'b0;
      irq_pending        <= 1'b0;
      wdt_timeout        <= 1'b0;
    end else begin
      save_d             <= req_save;
      wdt_d              <= req_wdt;
      power_save_exec    <= req_save & ~save_d;
      power_save_operand <= (req_save & ~save_d) ? req_op
                                                 : ~power_save_operand;
      irq_pending        <= req_irq;
      wdt_timeout        <= req_wdt & ~wdt_d;
    end
  end

endmodule

`default_nettype wire

// File: verification/pscg_power_save_clock_gating_bench.sv
// Self-checking bench for the power-save and clock-gating block.
// Assumes zero-wait APB and the core stand-in model beside the block.
`timescale 1ns/1ns
`default_nettype none

module pscg_power_save_clock_gating_bench;
  import pscg_pkg::*;

  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, d;
  logic        power_save_exec, power_save_operand, irq_pending;
  logic        wdt_timeout, wdt_enabled, clock_failure_monitor_enabled, e;
  logic [2:0]  current_clock_select, restart_clock_select;
  logic        cpu_clk_en, cpu_resume, sys_clk_run, osc_on;
  logic        low_power_rc_run, clock_failure_monitor_active, wdt_clear, periph_sysclk_en;
  logic [15:0] module_gate_en1, module_gate_en2, old;
  logic        analog_cfg_en, req_save, req_op, req_irq, req_wdt, s2;
  int          fails, cmp_count, res_cnt, clr_cnt, n, k;
  time         t_rel;

  always #50 core_clk = ~core_clk;

  pscg_power_save_clock_gating dut (.core_clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_save_exec,
    .power_save_operand, .irq_pending, .wdt_timeout, .wdt_enabled,
    .clock_failure_monitor_enabled, .current_clock_select, .cpu_clk_en, .cpu_resume,
    .sys_clk_run, .osc_on, .low_power_rc_run, .clock_failure_monitor_active, .wdt_clear,
    .periph_sysclk_en, .module_gate_en1, .module_gate_en2, .analog_cfg_en,
    .restart_clock_select);

  pscg_core_model core (.core_clk, .sys_rst, .req_save, .req_op, .req_irq,
    .req_wdt, .power_save_exec, .power_save_operand, .irq_pending,
    .wdt_timeout);

  ////////////////////////////////////////////////////////////////////////
  // Pulse counters, updated by NBA so readers never race them
  always @(posedge core_clk) begin
    if (cpu_resume === 1'b1) res_cnt <= res_cnt + 1;
    if (wdt_clear === 1'b1) clr_cnt <= clr_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Expected enables: a set disable bit clears its enable
  function automatic logic [15:0] exp_gate(input logic sel, logic [31:0] v);
    return ~v[15:0] & (sel ? PSCG_GATE2_MASK : PSCG_GATE1_MASK);
  endfunction

  // {sys clk, osc, periph clk, cpu clk, monitor, slow rc} while halted
  function automatic logic [5:0] exp_pwr(input logic op, w, f);
    return (op == PSCG_OP_SLEEP) ? {5'h00, w} : {4'hE, f, w | f};
  endfunction

  task chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task chk_rng(input int got, lo, hi, input string m);
    cmp_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("wrong value at %0t: %s latency %0d", $time, m, got);
    end
  endtask

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    // A call straight after the last one lets an edge pass first, so no
    // strobe is assigned twice in one time step
    if ($time == t_rel) @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    t_rel = $time;
  endtask

  // Enter sleep or idle, optionally with a coincident interrupt
  task run_save(input logic op, input logic coinc);
    int c0, r0;
    c0 = clr_cnt;
    r0 = res_cnt;
    req_op   <= op;
    req_save <= 1'b1;
    req_irq  <= coinc;
    if (!coinc) begin
      repeat (4) @(posedge core_clk);
      chk({sys_clk_run, osc_on, periph_sysclk_en, cpu_clk_en, clock_failure_monitor_active,
        low_power_rc_run}, exp_pwr(op, wdt_enabled, clock_failure_monitor_enabled),
        "halted clocks");
      if (op == PSCG_OP_SLEEP)
        chk(restart_clock_select, current_clock_select, "restart");
      if ($urandom % 2) req_irq <= 1'b1;
      else req_wdt <= 1'b1;
    end
    n = 0;
    while (res_cnt == r0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (coinc) chk_rng(n, 7, 9, "coincident wake");
    else chk_rng(n, 6, 8, "wake");
    chk(clr_cnt - c0, 1, "wdt clear");
    req_save <= 1'b0;
    req_irq  <= 1'b0;
    req_wdt  <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(cpu_clk_en, 1, "cpu running");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard, sized well above the fewer than one thousand cycles of the run
  initial begin
    repeat (8000) @(posedge core_clk);
    fails++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {core_clk, psel, penable, pwrite, paddr, pwdata} = '0;
    {req_save, req_op, req_irq, req_wdt, wdt_enabled, clock_failure_monitor_enabled} = '0;
    {fails, cmp_count, res_cnt, clr_cnt} = '0;
    current_clock_select = 3'h0;
    sys_rst = 1'b1;
    void'($urandom(32'hBF784D00));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk({module_gate_en1, module_gate_en2},
      {PSCG_GATE1_MASK, PSCG_GATE2_MASK}, "gate reset");
    chk(analog_cfg_en, 1, "analog reset");
    apb(1'b0, PSCG_CLOCK_DIVIDER_REGISTER_OFS, 32'h0);
    chk(r, 32'h0, "clock_divider_register reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    // Gate registers: all-ones, all-zeros, then random words
    for (int i = 0; i < 14; i++) begin
      d  = (i < 2) ? 32'hFFFFFFFF : (i < 4) ? 32'h0 : $urandom;
      s2 = i[0];
      old = s2 ? module_gate_en2 : module_gate_en1;
      apb(1'b1, s2 ? PSCG_GATE2_OFS : PSCG_GATE1_OFS, d);
      @(posedge core_clk);
      chk(s2 ? module_gate_en2 : module_gate_en1, old, "gate early");
      @(posedge core_clk);
      chk(s2 ? module_gate_en2 : module_gate_en1, exp_gate(s2, d),
        "gate late");
      if (!s2) chk(analog_cfg_en, !d[0], "analog");
      apb(1'b0, s2 ? PSCG_GATE2_OFS : PSCG_GATE1_OFS, 32'h0);
      // Read-back is the written word on implemented bits only
      chk(r, {16'h0000, exp_gate(s2, ~d)}, "gate read");
    end
    // Doze: every ratio gives one CPU enable per 2^n core cycles
    for (int q = 0; q < 8; q++) begin
      apb(1'b1, PSCG_CLOCK_DIVIDER_REGISTER_OFS, 32'h0800 | (q << 12));
      repeat (4) @(posedge core_clk);
      k = 0;
      repeat (2 << q) begin
        @(posedge core_clk);
        k += (cpu_clk_en === 1'b1);
      end
      chk(k, 2, "doze ratio");
    end
    // Interrupt ends doze only with return-on-interrupt set
    for (int q = 0; q < 2; q++) begin
      apb(1'b1, PSCG_CLOCK_DIVIDER_REGISTER_OFS, q ? 32'hB800 : 32'h3800);
      req_irq <= 1'b1;
      repeat (6) @(posedge core_clk);
      apb(1'b0, PSCG_CLOCK_DIVIDER_REGISTER_OFS, 32'h0);
      chk(r, q ? 32'hB000 : 32'h3800, "return on irq");
      req_irq <= 1'b0;
      apb(1'b1, PSCG_CLOCK_DIVIDER_REGISTER_OFS, 32'h0);
    end
    // Sleep and idle with random monitor, watchdog and clock source
    for (int i = 0; i < 8; i++) begin
      {wdt_enabled, clock_failure_monitor_enabled, current_clock_select} <= 5'($urandom);
      @(posedge core_clk);
      run_save(i[0], i >= 6);
    end
    // Reset in mid-sleep: back to run with every present module enabled
    apb(1'b1, PSCG_GATE1_OFS, 32'h0000FFFF);
    req_op   <= PSCG_OP_SLEEP;
    req_save <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(sys_clk_run, 0, "asleep before reset");
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst  <= 1'b0;
    req_save <= 1'b0;
    @(posedge core_clk);
    chk({sys_clk_run, osc_on, periph_sysclk_en}, 3'h7, "reset wake");
    chk(module_gate_en1, PSCG_GATE1_MASK, "gate after reset");
    @(posedge core_clk);
    chk(cpu_clk_en, 1, "run after reset");
    end_of_test();
  end

endmodule

`default_nettype wire
